// file: logic/sop_slot_otp_policy.sv
// Slot and OTP access policy engine with a classic Wishbone register slave
//
// How it works
// - Secrecy bit 7 clear: plain access, no derivation; set: encrypted reads only.
// - Bit 6 set needs secret slot and encrypted read; clear allows plain reads.
// - Bit 5 gates key use of slots 0-7 and 15 on remaining-use bits; clear means unlimited.
// - Bit 4 set limits key use of the slot to MAC verify and digest commands.
// - Bits 3-0 name the key slot for encrypted reads.
// - Derivation: bit 13 enables, bit 12 picks parent key, bit 15 needs MAC.
// - Policy bits 15..13 zero: plain 32-byte writes accepted; 4-byte ones only to non-secret slots.
// - Bit 14 clear with bit 13 or 15 set: every write refused.
// - Bit 14 set: write needs MAC and encryption under write key; no 4-byte.
// - Write and derivation permissions share one policy field; bits 13 and 15 affect both.
// - Any 4-byte access to a secret slot is refused.
// - Key rotation: encrypted writes authorised by the slot's own current key.
// - Identity bytes 0 to 12 always readable, never writable.
// - Three fixed serial bytes always enter hash input.
// - Six per-die serial bytes enter hash input only when selected.
// - OTP refuses all access until the configuration zone is locked.
// - Config locked, data open: OTP writes accepted, OTP reads refused.
// - Read-only mode: writes refused unchanged; all words readable, 4 or 32 bytes.
// - Consumption mode: write stores data AND current word.
// - Legacy mode: words 0,1 and 32-byte reads refused, writes refused.
// - OTP bits reset to one; word n sits at byte 4n.
// - Mode byte 0xAA read-only, 0x55 consumption, 0x00 legacy, others reserved.
// - Data lock byte 0x55 means open; any other value enforces policies.
// - Config lock byte 0x55 means writable, anything else read-only.
`timescale 1ns/1ps
`default_nettype none
module sop_slot_otp_policy
   import sop_pkg::*;
#(
   parameter logic [23:0] SN_FIXED = 24'h5A5A5A,          // Arbitrary value
   parameter logic [47:0] SN_DIE   = 48'h123456789ABC,    // Arbitrary value
   parameter logic [31:0] REVISION = 32'h0000C0DE         // Arbitrary value
) (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   output var  sop_result_t result_o,
   output var  logic        result_valid_o,
   output var  logic [71:0] hash_serial_o
);
   // ==========================================================
   // Helpers
   function automatic logic [31:0] apply_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] clear_one(input logic [31:0] v);
      return v & (v - 32'h00000001);
   endfunction

   function automatic sop_result_t eval_cmd(input sop_cmd_t c, input logic [15:0] cfg,
                                            input logic cfg_locked, input logic data_locked,
                                            input logic [7:0] otp_mode, input logic budget_ok);
      sop_result_t r;
      logic        ok;
      logic [3:0]  wp;
      logic        secret;
      r      = '0;
      ok     = 1'b0;
      wp     = cfg[SC_WP_LSB +: 4];
      secret = cfg[SC_SECRET];
      unique case (c.op)
         OP_READ_SLOT: begin
            if (cfg_locked && data_locked && !(secret && !c.size32)) begin
               if (!secret && !cfg[SC_ENC_READ]) begin
                  ok = 1'b1;
               end else if (secret && cfg[SC_ENC_READ] && c.encrypted) begin
                  ok          = 1'b1;
                  r.encrypted = 1'b1;
                  r.key_slot  = cfg[SC_RKEY_LSB +: 4];
               end
            end
         end
         OP_WRITE_SLOT: begin
            if (cfg_locked) begin
               if (!data_locked) begin
                  ok = 1'b1;
               end else if (secret && !c.size32) begin
                  ok = 1'b0;
               end else if (wp[3:1] == 3'b000) begin
                  ok = 1'b1;
               end else if (wp[WP_ENC]) begin
                  ok          = c.encrypted && c.mac_ok && c.size32;
                  r.encrypted = 1'b1;
                  r.mac_req   = 1'b1;
                  r.key_slot  = cfg[SC_WKEY_LSB +: 4];
               end
               // Remaining codes never accept a write command
            end
         end
         OP_DERIVE: begin
            if (cfg_locked && data_locked && secret && wp[WP_DERIVE]
                && (!wp[WP_MAC] || c.mac_ok)) begin
               ok = 1'b1;
            end
            r.mac_req  = wp[WP_MAC];
            r.key_slot = wp[WP_PARENT] ? cfg[SC_WKEY_LSB +: 4] : c.index;
         end
         OP_READ_OTP: begin
            if (cfg_locked && data_locked) begin
               unique case (otp_mode)
                  OTP_MODE_RO:      ok = 1'b1;
                  OTP_MODE_CONSUME: ok = 1'b1;
                  OTP_MODE_LEGACY:  ok = (c.index >= LEGACY_FIRST_WORD) && !c.size32;
                  default:          ok = 1'b0;
               endcase
            end
         end
         OP_WRITE_OTP: begin
            if (cfg_locked) begin
               ok = !data_locked || (otp_mode == OTP_MODE_CONSUME);
            end
            r.encrypted = c.encrypted;
         end
         OP_KEY_USE, OP_VERIFY_USE, OP_DIGEST_USE: begin
            ok = cfg_locked && data_locked && budget_ok
                 && !(cfg[SC_VERIFY] && (c.op == OP_KEY_USE));
            r.key_slot = c.index;
         end
      endcase
      r.grant = ok;
      r.error = !ok;
      return r;
   endfunction

   // ==========================================================
   // State
   logic [3:0]  slot_sel_reg;
   logic [15:0] slot_cfg_reg [16];
   logic [7:0]  cfg_lock_reg;
   logic [7:0]  data_lock_reg;
   logic [7:0]  otp_mode_reg;
   logic [7:0]  use_reg [8];
   logic [31:0] slot15_reg;
   logic [31:0] data_reg;
   logic [31:0] otp_reg [16];
   sop_result_t result_reg;
   logic        result_valid_reg;
   logic [71:0] hash_serial_reg;
   logic [31:0] rd_next;
   logic        ack_reg;
   logic [31:0] dat_reg;

   // ==========================================================
   // Bus decode and command evaluation
   logic        req;
   logic        wr_fire;
   logic        cmd_fire;
   sop_cmd_t    cmd_in;
   logic [15:0] cmd_cfg;
   logic        cfg_locked;
   logic        data_locked;
   logic        budget_ok;
   sop_result_t res_next;
   logic [31:0] locks_word;
   logic [31:0] wdat;
   logic [31:0] cfg_wword;
   logic [31:0] use_cleared;

   assign req         = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wr_fire     = req && wb_we_i;
   assign cmd_fire    = wr_fire && (wb_adr_i == ADDR_CMD);
   assign cmd_in      = sop_cmd_t'(wb_dat_i[CMD_W-1:0]);
   assign cmd_cfg     = slot_cfg_reg[cmd_in.index];
   assign cfg_locked  = (cfg_lock_reg != LOCK_OPEN);
   assign data_locked = (data_lock_reg != LOCK_OPEN);
   assign budget_ok   = !cmd_cfg[SC_CAP]
                        || (!cmd_in.index[3] ? (use_reg[cmd_in.index[2:0]] != 8'h00)
                        : (cmd_in.index == SLOT_LAST) ? (slot15_reg != 32'h00000000) : 1'b1);
   assign res_next    = eval_cmd(cmd_in, cmd_cfg, cfg_locked, data_locked, otp_mode_reg, budget_ok);
   assign locks_word  = {8'h00, otp_mode_reg, data_lock_reg, cfg_lock_reg};
   assign wdat        = apply_sel(locks_word, wb_dat_i, wb_sel_i);
   assign cfg_wword   = apply_sel({16'h0000, slot_cfg_reg[slot_sel_reg]}, wb_dat_i, wb_sel_i);
   assign use_cleared = clear_one({24'h000000, use_reg[cmd_in.index[2:0]]});

   // ==========================================================
   // Wishbone answer, registered ack one cycle after the request
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         ack_reg <= req;
         if (req && !wb_we_i) begin
            dat_reg <= rd_next;
         end
      end
   end

   always_comb begin
      rd_next = 32'h00000000;
      unique case (wb_adr_i)
         ADDR_SLOT_SEL: rd_next = {28'h0000000, slot_sel_reg};
         ADDR_SLOT_CFG: rd_next = {16'h0000, slot_cfg_reg[slot_sel_reg]};
         ADDR_LOCKS:    rd_next = locks_word;
         ADDR_USE_LO:   rd_next = {use_reg[3], use_reg[2], use_reg[1], use_reg[0]};
         ADDR_USE_HI:   rd_next = {use_reg[7], use_reg[6], use_reg[5], use_reg[4]};
         ADDR_SLOT15:   rd_next = slot15_reg;
         ADDR_DATA:     rd_next = data_reg;
         ADDR_STATUS:   rd_next = {23'h000000, result_valid_reg, result_reg};
         ADDR_IDENT0:   rd_next = {SN_DIE[39:32], SN_DIE[47:40], SN_FIXED[15:8], SN_FIXED[23:16]};
         ADDR_IDENT1:   rd_next = REVISION;
         ADDR_IDENT2:   rd_next = {SN_DIE[7:0], SN_DIE[15:8], SN_DIE[23:16], SN_DIE[31:24]};
         ADDR_IDENT3:   rd_next = {24'h000000, SN_FIXED[7:0]};
         default:       rd_next = 32'h00000000;
      endcase
   end

   // ==========================================================
   // Configuration, locks and use budgets
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         slot_sel_reg  <= 4'h0;
         cfg_lock_reg  <= LOCK_RST;
         data_lock_reg <= LOCK_RST;
         otp_mode_reg  <= OTP_MODE_RST;
         for (int i = 0; i < 16; i++) begin
            slot_cfg_reg[i] <= SLOT_CFG_RST;
         end
      end else if (wr_fire) begin
         if (wb_adr_i == ADDR_SLOT_SEL && wb_sel_i[0]) begin
            slot_sel_reg <= wb_dat_i[3:0];
         end
         if (wb_adr_i == ADDR_SLOT_CFG && !cfg_locked) begin
            slot_cfg_reg[slot_sel_reg] <= cfg_wword[15:0];
         end
         if (wb_adr_i == ADDR_LOCKS) begin
            if (!cfg_locked) begin
               cfg_lock_reg <= wdat[LK_CFG_LSB +: 8];
               otp_mode_reg <= wdat[LK_MODE_LSB +: 8];
            end else if (!data_locked) begin
               data_lock_reg <= wdat[LK_DATA_LSB +: 8];
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         slot15_reg <= SLOT15_RST;
         for (int i = 0; i < 8; i++) begin
            use_reg[i] <= USE_RST;
         end
      end else if (wr_fire && !cfg_locked) begin
         if (wb_adr_i == ADDR_USE_LO) begin
            {use_reg[3], use_reg[2], use_reg[1], use_reg[0]} <=
               apply_sel({use_reg[3], use_reg[2], use_reg[1], use_reg[0]}, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == ADDR_USE_HI) begin
            {use_reg[7], use_reg[6], use_reg[5], use_reg[4]} <=
               apply_sel({use_reg[7], use_reg[6], use_reg[5], use_reg[4]}, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == ADDR_SLOT15) begin
            slot15_reg <= apply_sel(slot15_reg, wb_dat_i, wb_sel_i);
         end
      end else if (cmd_fire && res_next.grant && cmd_cfg[SC_CAP]
                   && (cmd_in.op inside {OP_KEY_USE, OP_VERIFY_USE, OP_DIGEST_USE})) begin
         if (!cmd_in.index[3]) begin
            use_reg[cmd_in.index[2:0]] <= use_cleared[7:0];
         end else if (cmd_in.index == SLOT_LAST) begin
            slot15_reg <= clear_one(slot15_reg);
         end
      end
   end

   // ==========================================================
   // Data word and OTP array
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         data_reg <= 32'h00000000;
         for (int i = 0; i < 16; i++) begin
            otp_reg[i] <= OTP_WORD_RST;
         end
      end else if (cmd_fire && res_next.grant && cmd_in.op == OP_WRITE_OTP) begin
         if (data_locked) begin
            otp_reg[cmd_in.index] <= otp_reg[cmd_in.index] & data_reg;
         end else begin
            otp_reg[cmd_in.index] <= data_reg;
         end
      end else if (cmd_fire && res_next.grant && cmd_in.op == OP_READ_OTP) begin
         data_reg <= otp_reg[cmd_in.index];
      end else if (wr_fire && wb_adr_i == ADDR_DATA) begin
         data_reg <= apply_sel(data_reg, wb_dat_i, wb_sel_i);
      end
   end

   // ==========================================================
   // Command answer and hash serial input
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         result_reg       <= '0;
         result_valid_reg <= 1'b0;
         hash_serial_reg  <= 72'h000000000000000000;
      end else begin
         result_valid_reg <= cmd_fire;
         if (cmd_fire) begin
            result_reg      <= res_next;
            hash_serial_reg <= {SN_FIXED[23:8], (cmd_in.include_die ? SN_DIE : 48'h000000000000),
                                SN_FIXED[7:0]};
         end
      end
   end

   assign wb_ack_o       = ack_reg;
   assign wb_dat_o       = dat_reg;
   assign result_o       = result_reg;
   assign result_valid_o = result_valid_reg;
   assign hash_serial_o  = hash_serial_reg;

   // ==========================================================
   // Assertions
   a_ack_single_cycle: assert property (@(posedge ref_clk) disable iff (!nrst)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle after request");
   a_otp_cfg_open: assert property (@(posedge ref_clk) disable iff (!nrst)
      cmd_fire && !cfg_locked && (cmd_in.op inside {OP_READ_OTP, OP_WRITE_OTP})
      |=> result_valid_o && result_o.error && !result_o.grant)
      else $error("OTP access granted before config lock");
   a_otp_read_open: assert property (@(posedge ref_clk) disable iff (!nrst)
      cmd_fire && !data_locked && cmd_in.op == OP_READ_OTP |=> result_o.error)
      else $error("OTP read granted while data zone open");
   a_secret_short: assert property (@(posedge ref_clk) disable iff (!nrst)
      cmd_fire && data_locked && cmd_cfg[SC_SECRET] && !cmd_in.size32
      && (cmd_in.op inside {OP_READ_SLOT, OP_WRITE_SLOT}) |=> result_o.error)
      else $error("short access to secret slot granted");
   a_never_write: assert property (@(posedge ref_clk) disable iff (!nrst)
      cmd_fire && cfg_locked && data_locked && cmd_in.op == OP_WRITE_SLOT && !cmd_cfg[SC_WP_LSB + WP_ENC]
      && (cmd_cfg[SC_WP_LSB + WP_DERIVE] || cmd_cfg[SC_WP_LSB + WP_MAC]) |=> result_o.error)
      else $error("write granted to never-writable slot");
   a_derive_plain: assert property (@(posedge ref_clk) disable iff (!nrst)
      cmd_fire && !cmd_cfg[SC_SECRET] && cmd_in.op == OP_DERIVE |=> result_o.error)
      else $error("derivation granted on non-secret slot");
   a_legacy_low: assert property (@(posedge ref_clk) disable iff (!nrst)
      cmd_fire && data_locked && otp_mode_reg == OTP_MODE_LEGACY && cmd_in.op == OP_READ_OTP
      && (cmd_in.index < LEGACY_FIRST_WORD || cmd_in.size32) |=> result_o.error)
      else $error("legacy OTP read of protected word granted");
   a_ro_keeps: assert property (@(posedge ref_clk) disable iff (!nrst)
      cmd_fire && cfg_locked && data_locked && otp_mode_reg == OTP_MODE_RO && cmd_in.op == OP_WRITE_OTP
      |=> result_o.error && otp_reg[$past(cmd_in.index)] == $past(otp_reg[cmd_in.index]))
      else $error("read-only OTP word altered");
   a_consume_and: assert property (@(posedge ref_clk) disable iff (!nrst)
      cmd_fire && cfg_locked && data_locked && otp_mode_reg == OTP_MODE_CONSUME && cmd_in.op == OP_WRITE_OTP
      |=> otp_reg[$past(cmd_in.index)] == ($past(otp_reg[cmd_in.index]) & $past(data_reg)))
      else $error("consumption write is not an AND");
   a_die_masked: assert property (@(posedge ref_clk) disable iff (!nrst)
      cmd_fire && !cmd_in.include_die |=> hash_serial_o[55:8] == 48'h000000000000
      && hash_serial_o[71:56] == SN_FIXED[23:8])
      else $error("die serial leaked into hash input");
   a_use_spent: assert property (@(posedge ref_clk) disable iff (!nrst)
      cmd_fire && cmd_cfg[SC_CAP] && !cmd_in.index[3] && use_reg[cmd_in.index[2:0]] == 8'h00
      && (cmd_in.op inside {OP_KEY_USE, OP_VERIFY_USE, OP_DIGEST_USE}) |=> result_o.error)
      else $error("use granted with spent budget");
endmodule
`default_nettype wire

// file: logic/sop_pkg.sv
// Constants, types and register map of the slot and OTP access policy block
`default_nettype none
package sop_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0]  ADDR_SLOT_SEL = 8'h00;
   localparam logic [7:0]  ADDR_SLOT_CFG = 8'h04;
   localparam logic [7:0]  ADDR_LOCKS    = 8'h08;
   localparam logic [7:0]  ADDR_USE_LO   = 8'h0C;
   localparam logic [7:0]  ADDR_USE_HI   = 8'h10;
   localparam logic [7:0]  ADDR_SLOT15   = 8'h14;
   localparam logic [7:0]  ADDR_DATA     = 8'h18;
   localparam logic [7:0]  ADDR_CMD      = 8'h1C;
   localparam logic [7:0]  ADDR_STATUS   = 8'h20;
   localparam logic [7:0]  ADDR_IDENT0   = 8'h40;
   localparam logic [7:0]  ADDR_IDENT1   = 8'h44;
   localparam logic [7:0]  ADDR_IDENT2   = 8'h48;
   localparam logic [7:0]  ADDR_IDENT3   = 8'h4C;
   // ==========================================================
   // Lock and OTP mode codes
   localparam logic [7:0]  LOCK_OPEN        = 8'h55;
   localparam logic [7:0]  OTP_MODE_RO      = 8'hAA;
   localparam logic [7:0]  OTP_MODE_CONSUME = 8'h55;
   localparam logic [7:0]  OTP_MODE_LEGACY  = 8'h00;
   // ==========================================================
   // Field positions
   localparam int          SC_SECRET   = 7;
   localparam int          SC_ENC_READ = 6;
   localparam int          SC_CAP      = 5;
   localparam int          SC_VERIFY   = 4;
   localparam int          SC_RKEY_LSB = 0;
   localparam int          SC_WKEY_LSB = 8;
   localparam int          SC_WP_LSB   = 12;
   localparam int          WP_MAC      = 3;
   localparam int          WP_ENC      = 2;
   localparam int          WP_DERIVE   = 1;
   localparam int          WP_PARENT   = 0;
   localparam int          LK_CFG_LSB  = 0;
   localparam int          LK_DATA_LSB = 8;
   localparam int          LK_MODE_LSB = 16;
   localparam logic [3:0]  SLOT_LAST   = 4'hF;
   localparam logic [3:0]  LEGACY_FIRST_WORD = 4'h2;
   // ==========================================================
   // Reset values
   localparam logic [15:0] SLOT_CFG_RST = 16'h0000;
   localparam logic [7:0]  USE_RST      = 8'hFF;
   localparam logic [31:0] SLOT15_RST   = 32'hFFFFFFFF;
   localparam logic [31:0] OTP_WORD_RST = 32'hFFFFFFFF;
   localparam logic [7:0]  LOCK_RST     = 8'h55;
   localparam logic [7:0]  OTP_MODE_RST = 8'hAA;
   // ==========================================================
   // Commands and answers
   typedef enum logic [2:0] {
      OP_READ_SLOT, OP_WRITE_SLOT, OP_DERIVE, OP_READ_OTP,
      OP_WRITE_OTP, OP_KEY_USE, OP_VERIFY_USE, OP_DIGEST_USE
   } sop_op_t;
   typedef struct packed {
      logic       include_die;
      logic       mac_ok;
      logic       encrypted;
      logic       size32;
      logic [3:0] index;
      sop_op_t    op;
   } sop_cmd_t;
   typedef struct packed {
      logic       grant;
      logic       error;
      logic       mac_req;
      logic       encrypted;
      logic [3:0] key_slot;
   } sop_result_t;
   localparam int          CMD_W = $bits(sop_cmd_t);
   localparam int          RES_W = $bits(sop_result_t);
endpackage
`default_nettype wire

// file: test/sop_host_model.sv
// Wishbone host model issuing register and command traffic
`timescale 1ns/1ps
`default_nettype none
module sop_host_model (
   input  wire logic        ref_clk,
   output var  logic        cyc = 1'b0,
   output var  logic        stb = 1'b0,
   output var  logic        we  = 1'b0,
   output var  logic [7:0]  adr = 8'h00,
   output var  logic [3:0]  sel = 4'h0,
   output var  logic [31:0] dat = 32'h00000000,
   input  wire logic [31:0] rdat,
   input  wire logic        ack
);
   // ==========================================================
   // One classic cycle, held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= 4'hF;
      dat <= d;
      forever begin
         @(posedge ref_clk);
         if (ack === 1'b1) break;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      adr <= ~a;
      dat <= ~d;
   endtask
endmodule
`default_nettype wire

// file: test/slot_otp_access_policy_bench.sv
// Self-checking bench of the slot and OTP access policy block
`timescale 1ns/1ps
`default_nettype none
module slot_otp_access_policy_bench;
   import sop_pkg::*;
   localparam logic [23:0] FIX = 24'hA1B2C3;         // Arbitrary value
   localparam logic [47:0] DIE = 48'h0F1E2D3C4B5A;   // Arbitrary value
   localparam logic [31:0] REV = 32'h00005A17;       // Arbitrary value
   logic        ref_clk;
   logic        nrst;
   logic        cyc, stb, we, ack, rv;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, s;
   logic [71:0] hash;
   sop_result_t res;
   int          n_errors = 0;
   int          check_count = 0;
   sop_host_model i_host (.ref_clk(ref_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wdat),
                          .rdat(rdat), .ack(ack));
   sop_slot_otp_policy #(.SN_FIXED(FIX), .SN_DIE(DIE), .REVISION(REV)) i_dut (.ref_clk(ref_clk), .nrst(nrst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .result_o(res), .result_valid_o(rv), .hash_serial_o(hash));
   // ==========================================================
   // Shared helpers
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      i_host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      i_host.xfer(1'b0, a, 32'h00000000, q);
      chk(q, e);
   endtask
   // Flags f = {include_die, mac_ok, encrypted, size32}; ge = {grant, error}
   task automatic cmd(input sop_op_t op, input logic [3:0] ix, input logic [3:0] f, input logic [1:0] ge);
      wr(ADDR_CMD, {21'h0, f, ix, op});
      chk({rv, res.grant, res.error}, {1'b1, ge});
      i_host.xfer(1'b0, ADDR_STATUS, 32'h00000000, s);
      chk(s[7:6], ge);
      chk(hash, {FIX[23:8], f[3] ? DIE : 48'h0, FIX[7:0]});
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset_and_early_otp;
      rd_chk(ADDR_LOCKS, 32'h00AA5555);
      rd_chk(ADDR_SLOT15, 32'hFFFFFFFF);
      rd_chk(ADDR_IDENT0, 32'h1E0FB2A1);
      rd_chk(ADDR_IDENT3, 32'h000000C3);
      cmd(OP_WRITE_OTP, 4'h0, 4'h1, 2'b01);
      cmd(OP_READ_OTP, 4'h0, 4'h9, 2'b01);
   endtask
   task automatic t_configure;
      wr(ADDR_SLOT_SEL, 32'h2);
      wr(ADDR_SLOT_CFG, 32'h62C5);
      wr(ADDR_SLOT_SEL, 32'h0);
      wr(ADDR_SLOT_CFG, 32'h00B0);
      wr(ADDR_SLOT_SEL, 32'hF);
      wr(ADDR_SLOT_CFG, 32'h00A0);
      wr(ADDR_USE_LO, 32'hFFFFFF01);
      wr(ADDR_SLOT15, 32'h00000001);
      wr(ADDR_SLOT_SEL, 32'h1);
      wr(ADDR_LOCKS, 32'h00550000);
      rd_chk(ADDR_LOCKS, 32'h00555500);
      wr(ADDR_SLOT_CFG, 32'hFFFF);
      rd_chk(ADDR_SLOT_CFG, 32'h0000);
   endtask
   task automatic t_otp_open;
      wr(ADDR_DATA, 32'h0F0F00FF);
      cmd(OP_WRITE_OTP, 4'h3, 4'h0, 2'b10);
      cmd(OP_READ_OTP, 4'h3, 4'h0, 2'b01);
      cmd(OP_READ_SLOT, 4'h1, 4'h0, 2'b01);
      wr(ADDR_LOCKS, 32'h00550000);
      rd_chk(ADDR_LOCKS, 32'h00550000);
   endtask
   task automatic t_consume;
      wr(ADDR_DATA, 32'h33FF33FF);
      cmd(OP_WRITE_OTP, 4'h3, 4'h0, 2'b10);
      cmd(OP_READ_OTP, 4'h3, 4'h8, 2'b10);
      rd_chk(ADDR_DATA, 32'h030F00FF);
      cmd(OP_READ_OTP, 4'h5, 4'h0, 2'b10);
      rd_chk(ADDR_DATA, 32'hFFFFFFFF);
   endtask
   task automatic t_slots;
      cmd(OP_WRITE_SLOT, 4'h2, 4'h7, 2'b10);
      chk(s[3:0], 4'h2);
      cmd(OP_WRITE_SLOT, 4'h2, 4'h6, 2'b01);
      cmd(OP_DERIVE, 4'h2, 4'h0, 2'b10);
      chk(s[3:0], 4'h2);
      cmd(OP_WRITE_SLOT, 4'h1, 4'h0, 2'b10);
      cmd(OP_DERIVE, 4'h1, 4'h0, 2'b01);
   endtask
   task automatic t_uses;
      cmd(OP_KEY_USE, 4'h0, 4'h0, 2'b01);
      cmd(OP_VERIFY_USE, 4'h0, 4'h0, 2'b10);
      cmd(OP_DIGEST_USE, 4'h0, 4'h0, 2'b01);
      rd_chk(ADDR_USE_LO, 32'hFFFFFF00);
      cmd(OP_KEY_USE, 4'hF, 4'h0, 2'b10);
      cmd(OP_KEY_USE, 4'hF, 4'h0, 2'b01);
      rd_chk(ADDR_SLOT15, 32'h00000000);
      cmd(OP_KEY_USE, 4'h1, 4'h0, 2'b10);
      cmd(OP_READ_SLOT, 4'h2, 4'h3, 2'b10);
      chk(s[4:0], 5'h15);
      cmd(OP_READ_SLOT, 4'h2, 4'h1, 2'b01);
      cmd(OP_READ_SLOT, 4'h0, 4'h1, 2'b01);
      cmd(OP_READ_SLOT, 4'h1, 4'h0, 2'b10);
   endtask
   // Mid-run reset, then OTP words 1 and 2 written and both zones locked
   task automatic otp_setup(input logic [7:0] mode);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      rd_chk(ADDR_LOCKS, 32'h00AA5555);
      rd_chk(ADDR_STATUS, 32'h00000000);
      wr(ADDR_DATA, 32'h12345678);
      wr(ADDR_LOCKS, {8'h00, mode, 16'h0000});
      cmd(OP_WRITE_OTP, 4'h1, 4'h1, 2'b10);
      cmd(OP_WRITE_OTP, 4'h2, 4'h0, 2'b10);
      wr(ADDR_LOCKS, 32'h00000000);
      wr(ADDR_DATA, 32'h00000000);
      cmd(OP_WRITE_OTP, 4'h2, 4'h1, 2'b01);
   endtask
   task automatic t_otp_ro;
      otp_setup(OTP_MODE_RO);
      cmd(OP_READ_OTP, 4'h2, 4'h1, 2'b10);
      rd_chk(ADDR_DATA, 32'h12345678);
      cmd(OP_READ_OTP, 4'h0, 4'h0, 2'b10);
      rd_chk(ADDR_DATA, 32'hFFFFFFFF);
      wr(ADDR_IDENT1, 32'h00000000);
      rd_chk(ADDR_IDENT1, REV);
      rd_chk(ADDR_IDENT2, 32'h5A4B3C2D);
   endtask
   task automatic t_otp_legacy;
      otp_setup(OTP_MODE_LEGACY);
      cmd(OP_READ_OTP, 4'h1, 4'h0, 2'b01);
      cmd(OP_READ_OTP, 4'h2, 4'h1, 2'b01);
      cmd(OP_READ_OTP, 4'h2, 4'h0, 2'b10);
      rd_chk(ADDR_DATA, 32'h12345678);
      otp_setup(8'h3C);
      cmd(OP_READ_OTP, 4'h2, 4'h0, 2'b01);
   endtask
   // ==========================================================
   // Clock, reset, sequence and verdict
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #200000;
      n_errors++;
      end_of_test();
   end
   initial begin
      nrst = 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset_and_early_otp();
      t_configure();
      t_otp_open();
      t_consume();
      t_slots();
      t_uses();
      t_otp_ro();
      t_otp_legacy();
      end_of_test();
   end
endmodule
`default_nettype wire
